// >>> verilog/modulo_timer.sv
// Eight-bit modulo timer: register file, counter, overflow flag and interrupt.
// Assumes an AXI4-Lite master on aclk, a one-cycle fixed_tick enable and an ext_clk already synchronous to aclk.
//
// Overview of operation
// - Overflow flag sets when counter wraps to zero after reaching the modulo value.
// - Flag clears by a status read seeing it set, then writing zero to it.
// - Flag also clears on writing one to counter reset, or any modulo write.
// - Interrupt asserts while overflow enable and flag are both one; enable resets low.
// - Writing one to the write-only counter reset zeroes count, clears flag; reads zero.
// - Writing zero to counter reset does nothing; counting carries on.
// - While the halt bit is one the count holds; clearing it resumes counting.
// - Reset sets the halt bit, giving status/control the reset value 10h.
// - Unused low status/control bits read zero and ignore writes.
// - Six 8-bit registers at indices 18 to 1D; count is read-only, resets 00h.
// - Clock configuration and modulo are read/write and reset to 00h.
// - Modulo zero means free-running; any modulo write resets the count to zero.
// - Writes to the count register have no effect.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
module modulo_timer
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [modulo_timer_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [modulo_timer_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Count sources
  input wire logic fixed_tick,
  input wire logic ext_clk,
  // Interrupt
  output logic irq
);

  modulo_timer_pkg::bus_write_type wr;
  logic wr_go;
  logic wr_err;
  logic rd_go;
  logic [31:0] rd_data;
  logic rd_err;
  logic tick;

  logic overflow_flag;
  logic overflow_irq_enable;
  logic counter_halt_bit;
  logic clear_armed;
  logic [7:0] timer_clock_config;
  logic [7:0] timer_count_value;
  logic [7:0] timer_modulo_limit;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;

  logic next_overflow_flag;
  logic next_overflow_irq_enable;
  logic next_counter_halt_bit;
  logic next_clear_armed;
  logic [7:0] next_timer_clock_config;
  logic [7:0] next_timer_count_value;
  logic [7:0] next_timer_modulo_limit;
  logic [7:0] next_irq_status;
  logic [7:0] next_irq_mask;

  logic wr_lane;
  logic sc_write;
  logic mod_write;
  logic count_write;
  logic trst_write;
  logic flag_zero_write;
  logic overflow_event;
  logic count_run;
  logic [7:0] sc_value;
  modulo_timer_pkg::tick_config_type tick_cfg;

  // True when a bus address selects the given register index.
  function automatic logic hit(input logic [modulo_timer_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    return a == modulo_timer_pkg::reg_addr(idx);
  endfunction : hit

  // ==========================================================================
  // Bus front end and tick source
  axil_reg_port bus_port
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr(wr),
    .wr_go(wr_go),
    .wr_err(wr_err),
    .rd_go(rd_go),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign tick_cfg.src = modulo_timer_pkg::clk_src_type'(timer_clock_config[modulo_timer_pkg::CFG_SRC_LSB +: 2]);
  assign tick_cfg.ps = timer_clock_config[3:0];

  tick_prescaler prescaler
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .fixed_tick(fixed_tick),
    .ext_clk(ext_clk),
    .cfg(tick_cfg),
    .tick(tick)
  );

  // ==========================================================================
  // Address decode
  always_comb
  begin
    sc_value = 8'h00;
    sc_value[modulo_timer_pkg::SC_FLAG_BIT] = overflow_flag;
    sc_value[modulo_timer_pkg::SC_IRQEN_BIT] = overflow_irq_enable;
    sc_value[modulo_timer_pkg::SC_HALT_BIT] = counter_halt_bit;
    rd_err = 1'b0;
    if (hit(araddr, modulo_timer_pkg::IDX_STATUS_CONTROL))
    begin
      rd_data = {24'h000000, sc_value};
    end
    else if (hit(araddr, modulo_timer_pkg::IDX_CLOCK_CONFIG))
    begin
      rd_data = {24'h000000, timer_clock_config};
    end
    else if (hit(araddr, modulo_timer_pkg::IDX_COUNT_VALUE))
    begin
      rd_data = {24'h000000, timer_count_value};
    end
    else if (hit(araddr, modulo_timer_pkg::IDX_MODULO_LIMIT))
    begin
      rd_data = {24'h000000, timer_modulo_limit};
    end
    else if (hit(araddr, modulo_timer_pkg::IDX_IRQ_STATUS))
    begin
      rd_data = {24'h000000, irq_status};
    end
    else if (hit(araddr, modulo_timer_pkg::IDX_IRQ_MASK))
    begin
      rd_data = {24'h000000, irq_mask};
    end
    else
    begin
      rd_data = modulo_timer_pkg::READ_ZERO;
      rd_err = 1'b1;
    end
    wr_err = !(hit(wr.addr, modulo_timer_pkg::IDX_STATUS_CONTROL) || hit(wr.addr, modulo_timer_pkg::IDX_CLOCK_CONFIG)
      || hit(wr.addr, modulo_timer_pkg::IDX_COUNT_VALUE) || hit(wr.addr, modulo_timer_pkg::IDX_MODULO_LIMIT)
      || hit(wr.addr, modulo_timer_pkg::IDX_IRQ_STATUS) || hit(wr.addr, modulo_timer_pkg::IDX_IRQ_MASK));
    // A write without the low byte lane changes nothing.
    wr_lane = wr_go && wr.strb[0];
    sc_write = wr_lane && hit(wr.addr, modulo_timer_pkg::IDX_STATUS_CONTROL);
    mod_write = wr_lane && hit(wr.addr, modulo_timer_pkg::IDX_MODULO_LIMIT);
    count_write = wr_lane && hit(wr.addr, modulo_timer_pkg::IDX_COUNT_VALUE);
    trst_write = sc_write && wr.data[modulo_timer_pkg::SC_CLEAR_BIT];
    flag_zero_write = sc_write && !wr.data[modulo_timer_pkg::SC_FLAG_BIT] && clear_armed;
  end

  // ==========================================================================
  // Counter, flag and registers
  always_comb
  begin
    next_overflow_flag = overflow_flag;
    next_overflow_irq_enable = overflow_irq_enable;
    next_counter_halt_bit = counter_halt_bit;
    next_clear_armed = clear_armed;
    next_timer_clock_config = timer_clock_config;
    next_timer_count_value = timer_count_value;
    next_timer_modulo_limit = timer_modulo_limit;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    count_run = tick && !counter_halt_bit;
    overflow_event = 1'b0;
    if (count_run)
    begin
      if ((timer_modulo_limit != modulo_timer_pkg::MOD_FREE_RUN && timer_count_value == timer_modulo_limit)
        || (timer_modulo_limit == modulo_timer_pkg::MOD_FREE_RUN && timer_count_value == modulo_timer_pkg::COUNT_MAX))
      begin
        next_timer_count_value = modulo_timer_pkg::COUNT_RESET;
        overflow_event = 1'b1;
      end
      else
      begin
        next_timer_count_value = timer_count_value + modulo_timer_pkg::COUNT_STEP;
      end
    end
    if (trst_write || mod_write)
    begin
      next_timer_count_value = modulo_timer_pkg::COUNT_RESET;
    end
    // The count register ignores writes entirely.
    if (rd_go && hit(araddr, modulo_timer_pkg::IDX_STATUS_CONTROL) && overflow_flag)
    begin
      next_clear_armed = 1'b1;
    end
    else if (sc_write || !overflow_flag)
    begin
      next_clear_armed = 1'b0;
    end
    if (flag_zero_write || trst_write || mod_write)
    begin
      next_overflow_flag = 1'b0;
    end
    if (overflow_event)
    begin
      next_overflow_flag = 1'b1;
    end
    if (sc_write)
    begin
      next_overflow_irq_enable = wr.data[modulo_timer_pkg::SC_IRQEN_BIT];
      next_counter_halt_bit = wr.data[modulo_timer_pkg::SC_HALT_BIT];
    end
    if (wr_lane && hit(wr.addr, modulo_timer_pkg::IDX_CLOCK_CONFIG))
    begin
      next_timer_clock_config = wr.data[7:0] & modulo_timer_pkg::CFG_WRITE_MASK;
    end
    if (mod_write)
    begin
      next_timer_modulo_limit = wr.data[7:0];
    end
    if (wr_lane && hit(wr.addr, modulo_timer_pkg::IDX_IRQ_STATUS))
    begin
      next_irq_status = irq_status & ~wr.data[7:0];
    end
    if (overflow_event)
    begin
      next_irq_status[modulo_timer_pkg::IRQ_OVERFLOW_BIT] = 1'b1;
    end
    if (wr_lane && hit(wr.addr, modulo_timer_pkg::IDX_IRQ_MASK))
    begin
      next_irq_mask = wr.data[7:0] & modulo_timer_pkg::IRQ_LAYOUT;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
      counter_halt_bit <= modulo_timer_pkg::SC_RESET[modulo_timer_pkg::SC_HALT_BIT];
      clear_armed <= 1'b0;
      timer_clock_config <= modulo_timer_pkg::CFG_RESET;
      timer_count_value <= modulo_timer_pkg::COUNT_RESET;
      timer_modulo_limit <= modulo_timer_pkg::MOD_RESET;
      irq_status <= modulo_timer_pkg::IRQ_RESET;
      irq_mask <= modulo_timer_pkg::IRQ_RESET;
      irq <= 1'b0;
    end
    else
    begin
      overflow_flag <= next_overflow_flag;
      overflow_irq_enable <= next_overflow_irq_enable;
      counter_halt_bit <= next_counter_halt_bit;
      clear_armed <= next_clear_armed;
      timer_clock_config <= next_timer_clock_config;
      timer_count_value <= next_timer_count_value;
      timer_modulo_limit <= next_timer_modulo_limit;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= (next_overflow_flag && next_overflow_irq_enable) || ((next_irq_status & next_irq_mask) != 8'h00);
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_armed_read;
    rd_go && hit(araddr, modulo_timer_pkg::IDX_STATUS_CONTROL) && overflow_flag;
  endsequence

  a_overflow_sets_flag: assert property (overflow_event |=> overflow_flag)
    else $error("overflow did not set the flag");
  a_flag_fall_cause: assert property ($fell(overflow_flag) |-> $past(flag_zero_write || trst_write || mod_write))
    else $error("flag cleared without a legal cause");
  a_read_arms: assert property (s_armed_read |=> clear_armed)
    else $error("status read with the flag set did not arm the clear");
  a_armed_zero_clears: assert property (flag_zero_write && !overflow_event |=> !overflow_flag)
    else $error("read then zero write did not clear the flag");
  a_mod_write_clears: assert property (mod_write && !overflow_event |=> !overflow_flag && timer_count_value == 8'h00)
    else $error("modulo write did not clear flag and count");
  a_irq_follows: assert property (overflow_flag && overflow_irq_enable |-> irq)
    else $error("interrupt missing while enabled flag set");
  a_irq_needs_cause: assert property (irq |-> (overflow_flag && overflow_irq_enable)
    || ((irq_status & irq_mask) != 8'h00))
    else $error("interrupt without a cause");
  a_trst_zeroes: assert property (trst_write |=> timer_count_value == 8'h00 && $past(overflow_event) == overflow_flag)
    else $error("counter reset write did not zero count");
  a_sc_read_bits: assert property (sc_value[5:0] == {1'b0, counter_halt_bit, 4'h0})
    else $error("status control read shows write-only or reserved bits");
  a_zero_trst_keeps: assert property (sc_write && !trst_write && !count_run |=> $stable(timer_count_value))
    else $error("zero counter reset write changed the count");
  a_halt_holds: assert property (counter_halt_bit && !trst_write && !mod_write |=> $stable(timer_count_value))
    else $error("count moved while halted");
  a_reset_value: assert property ($rose(aresetn) |-> sc_value == 8'h10 && timer_count_value == 8'h00)
    else $error("status control reset value wrong");
  a_count_write_ignored: assert property (count_write && !count_run && !trst_write |=> $stable(timer_count_value))
    else $error("count register took a write");
  a_count_steps: assert property (count_run && !trst_write && !mod_write && !overflow_event
    |=> timer_count_value == $past(timer_count_value) + 8'h01)
    else $error("count did not step by one");

endmodule : modulo_timer

// >>> inc/modulo_timer_pkg.sv
// Constants, register map and carrier types of the modulo timer.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses four times the register index.
package modulo_timer_pkg;

  // ==========================================================================
  // Bus layout
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ==========================================================================
  // Register indices
  localparam logic [7:0] IDX_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] IDX_CLOCK_CONFIG = 8'h19;
  localparam logic [7:0] IDX_COUNT_VALUE = 8'h1a;
  localparam logic [7:0] IDX_MODULO_LIMIT = 8'h1b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h1d;

  // ==========================================================================
  // Fields and reset values
  localparam int SC_FLAG_BIT = 7;
  localparam int SC_IRQEN_BIT = 6;
  localparam int SC_CLEAR_BIT = 5;
  localparam int SC_HALT_BIT = 4;
  localparam logic [7:0] SC_RESET = 8'h10;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h3f;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_SRC_LSB = 4;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [7:0] MOD_RESET = 8'h00;
  localparam logic [7:0] MOD_FREE_RUN = 8'h00;
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam logic [7:0] IRQ_LAYOUT = 8'h01;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [3:0] PS_MAX = 4'h8;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {SRC_BUS, SRC_FIXED, SRC_EXT_FALL, SRC_EXT_RISE} clk_src_type;

  typedef struct packed {
    clk_src_type src;
    logic [3:0] ps;
  } tick_config_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } bus_write_type;

  // Byte address of a register index.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    logic [9:0] b;
    b = {idx, 2'b00};
    return b[ADDR_W-1:0];
  endfunction : reg_addr

endpackage : modulo_timer_pkg

// >>> verilog/tick_prescaler.sv
// Clock source selection and power-of-two prescaler producing the count tick.
// Assumes fixed_tick is a one-cycle enable and ext_clk is already synchronous to aclk.
`timescale 1ns/1ns
module tick_prescaler
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sources
  input wire logic fixed_tick,
  input wire logic ext_clk,
  // Selection
  input wire modulo_timer_pkg::tick_config_type cfg,
  // Output tick
  output logic tick
);

  logic [7:0] pre_count;
  logic [7:0] next_pre_count;
  logic ext_prev;
  logic next_tick;
  logic src_tick;

  // Mask of low prescaler bits that must all be one for a divided tick.
  function automatic logic [7:0] div_mask(input logic [3:0] ps);
    logic [8:0] m;
    m = 9'h001 << ps;
    if (ps >= modulo_timer_pkg::PS_MAX)
    begin
      return 8'hff;
    end
    return m[7:0] - 8'h01;
  endfunction : div_mask

  // ==========================================================================
  // Source select and division
  always_comb
  begin
    case (cfg.src)
      modulo_timer_pkg::SRC_BUS: src_tick = 1'b1;
      modulo_timer_pkg::SRC_FIXED: src_tick = fixed_tick;
      modulo_timer_pkg::SRC_EXT_FALL: src_tick = ext_prev && !ext_clk;
      default: src_tick = !ext_prev && ext_clk;
    endcase
    next_pre_count = pre_count;
    if (src_tick)
    begin
      next_pre_count = pre_count + 8'h01;
    end
    next_tick = src_tick && ((pre_count & div_mask(cfg.ps)) == div_mask(cfg.ps));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_count <= modulo_timer_pkg::PRESCALE_RESET;
      ext_prev <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      pre_count <= next_pre_count;
      ext_prev <= ext_clk;
      tick <= next_tick;
    end
  end

endmodule : tick_prescaler

// >>> verilog/axil_reg_port.sv
// AXI4-Lite slave front end: takes address and data in either order and hands one write or read to the core.
// Assumes the core answers rd_data and the error flags combinationally from the offered address.
`timescale 1ns/1ns
module axil_reg_port
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [modulo_timer_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [modulo_timer_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side
  output modulo_timer_pkg::bus_write_type wr,
  output logic wr_go,
  input wire logic wr_err,
  output logic rd_go,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;
  logic [1:0] next_bresp;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  modulo_timer_pkg::bus_write_type next_wr;

  // ==========================================================================
  // Handshakes
  always_comb
  begin
    awready = !aw_held && !bvalid;
    wready = !w_held && !bvalid;
    arready = !rvalid;
    wr_go = aw_held && w_held && !bvalid;
    rd_go = arvalid && arready;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr = wr;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_wr.addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_wr.data = wdata;
      next_wr.strb = wstrb;
    end
    if (wr_go)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_err ? modulo_timer_pkg::RESP_SLVERR : modulo_timer_pkg::RESP_OKAY;
    end
    else if (bvalid && bready)
    begin
      next_bvalid = 1'b0;
    end
    if (rd_go)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_data;
      next_rresp = rd_err ? modulo_timer_pkg::RESP_SLVERR : modulo_timer_pkg::RESP_OKAY;
    end
    else if (rvalid && rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr <= '0;
      bvalid <= 1'b0;
      bresp <= modulo_timer_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= modulo_timer_pkg::RESP_OKAY;
      rdata <= modulo_timer_pkg::READ_ZERO;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr <= next_wr;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

endmodule : axil_reg_port

// >>> bench/tb.sv
// Self-checking testbench of the modulo timer: register map, counting, overflow flag and interrupt.
// Assumes the design's package is compiled first and the timer's top module is modulo_timer.
`timescale 1ns/1ns
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  // ==========================================================================
  // Signals
  localparam logic [1:0] ok = modulo_timer_pkg::RESP_OKAY;
  localparam logic [1:0] err = modulo_timer_pkg::RESP_SLVERR;
  typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp; logic [1:0] resp;} row_type;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic fixed_tick = 1'b0, ext_clk = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] c1;
  int fails = 0;
  int checks_done = 0;
  row_type rows [20] = '{'{1'b0, 8'h60, 8'h00, 8'h10, ok}, '{1'b0, 8'h64, 8'h00, 8'h00, ok},
    '{1'b0, 8'h68, 8'h00, 8'h00, ok}, '{1'b0, 8'h6c, 8'h00, 8'h00, ok}, '{1'b0, 8'h70, 8'h00, 8'h00, ok},
    '{1'b0, 8'h74, 8'h00, 8'h00, ok}, '{1'b0, 8'h84, 8'h00, 8'h00, err}, '{1'b1, 8'h68, 8'haa, 8'h00, ok},
    '{1'b0, 8'h68, 8'h00, 8'h00, ok}, '{1'b1, 8'h60, 8'h7f, 8'h00, ok}, '{1'b0, 8'h60, 8'h00, 8'h50, ok},
    '{1'b1, 8'h60, 8'h10, 8'h00, ok}, '{1'b1, 8'h64, 8'hff, 8'h00, ok}, '{1'b0, 8'h64, 8'h00, 8'h3f, ok},
    '{1'b1, 8'h64, 8'h00, 8'h00, ok}, '{1'b1, 8'h6c, 8'h5a, 8'h00, ok}, '{1'b0, 8'h6c, 8'h00, 8'h5a, ok},
    '{1'b1, 8'h6c, 8'h03, 8'h00, ok}, '{1'b1, 8'h84, 8'h01, 8'h00, err}, '{1'b0, 8'h60, 8'h00, 8'h10, ok}};

  always #50 aclk = ~aclk;

  modulo_timer uut
  (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .fixed_tick, .ext_clk, .irq
  );

  // ==========================================================================
  // Bus tasks
  // Readies are sampled at the falling edge, where they no longer move before the next rising edge.
  task wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic pa, pw, pb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    while (pb)
    begin
      @(negedge aclk);
      if (pa && awready) pa = 1'b0;
      if (pw && wready) pw = 1'b0;
      if (bvalid)
      begin
        pb = 1'b0;
        rs = bresp;
      end
      @(posedge aclk);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
      if (!pb) bready <= 1'b0;
    end
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic pa, pr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    pr = 1'b1;
    while (pr)
    begin
      @(negedge aclk);
      if (pa && arready) pa = 1'b0;
      if (rvalid)
      begin
        pr = 1'b0;
        v = rdata;
        rs = rresp;
      end
      @(posedge aclk);
      if (!pa) arvalid <= 1'b0;
      if (!pr) rready <= 1'b0;
    end
  endtask : rd

  // Count-source pulses: a one-cycle fixed tick, or an external clock high for three cycles.
  task pulse(input logic use_ext, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      ext_clk <= use_ext;
      fixed_tick <= !use_ext;
      @(posedge aclk);
      fixed_tick <= 1'b0;
      repeat (2) @(posedge aclk);
      ext_clk <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask : pulse

  task note(input string s);
    $display("test %s done", s);
  endtask : note

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Tests
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
      begin
        wr(rows[i].addr, rows[i].data, r);
        `CHECK(r, rows[i].resp)
      end
      else
      begin
        rd(rows[i].addr, d, r);
        `CHECK({r, d}, {rows[i].resp, 24'h0, rows[i].exp})
      end
    end
    note("register map");
    // Counting every bus clock with modulo 3, then halted.
    wr(8'h60, 8'h00, r);
    repeat (20) @(posedge aclk);
    wr(8'h60, 8'h10, r);
    rd(8'h68, d, r);
    c1 = d[7:0];
    `CHECK(c1 <= 8'h03, 1'b1)
    wr(8'h60, 8'h10, r);
    repeat (10) @(posedge aclk);
    rd(8'h68, d, r);
    `CHECK(d, {24'h0, c1})
    note("count and halt");
    // The zero writes above came without an armed read, so the flag must survive them.
    rd(8'h60, d, r);
    `CHECK(d, 32'h90)
    @(negedge aclk);
    `CHECK(irq, 1'b0)
    wr(8'h60, 8'h10, r);
    rd(8'h60, d, r);
    `CHECK(d, 32'h10)
    note("flag clear");
    wr(8'h60, 8'h40, r);
    repeat (20) @(posedge aclk);
    wr(8'h60, 8'h50, r);
    @(negedge aclk);
    `CHECK(irq, 1'b1)
    wr(8'h60, 8'h70, r);
    @(negedge aclk);
    `CHECK(irq, 1'b0)
    rd(8'h60, d, r);
    `CHECK(d, 32'h50)
    rd(8'h68, d, r);
    `CHECK(d, 32'h0)
    note("overflow interrupt");
    wr(8'h74, 8'h01, r);
    @(negedge aclk);
    `CHECK(irq, 1'b1)
    rd(8'h70, d, r);
    `CHECK(d, 32'h1)
    wr(8'h70, 8'h01, r);
    @(negedge aclk);
    `CHECK(irq, 1'b0)
    rd(8'h70, d, r);
    `CHECK(d, 32'h0)
    wr(8'h74, 8'h00, r);
    note("sticky status and mask");
    wr(8'h60, 8'h00, r);
    repeat (20) @(posedge aclk);
    wr(8'h60, 8'h10, r);
    wr(8'h6c, 8'h00, r);
    rd(8'h60, d, r);
    `CHECK(d, 32'h10)
    rd(8'h68, d, r);
    `CHECK(d, 32'h0)
    wr(8'h60, 8'h00, r);
    repeat (100) @(posedge aclk);
    wr(8'h60, 8'h10, r);
    rd(8'h68, d, r);
    `CHECK(d[7:0] > 8'h03, 1'b1)
    rd(8'h60, d, r);
    `CHECK(d, 32'h10)
    wr(8'h60, 8'h00, r);
    repeat (200) @(posedge aclk);
    wr(8'h60, 8'h10, r);
    rd(8'h60, d, r);
    `CHECK(d, 32'h90)
    wr(8'h60, 8'h10, r);
    note("modulo write and free run");
    wr(8'h6c, 8'h00, r);
    wr(8'h64, 8'h30, r);
    wr(8'h60, 8'h00, r);
    pulse(1'b1, 3);
    wr(8'h60, 8'h00, r);
    pulse(1'b1, 2);
    wr(8'h60, 8'h10, r);
    rd(8'h68, d, r);
    `CHECK(d, 32'h5)
    wr(8'h64, 8'h20, r);
    wr(8'h6c, 8'h00, r);
    wr(8'h60, 8'h00, r);
    pulse(1'b1, 3);
    wr(8'h60, 8'h10, r);
    rd(8'h68, d, r);
    `CHECK(d, 32'h3)
    wr(8'h64, 8'h11, r);
    wr(8'h6c, 8'h00, r);
    wr(8'h60, 8'h00, r);
    pulse(1'b0, 4);
    wr(8'h60, 8'h10, r);
    rd(8'h68, d, r);
    `CHECK(d, 32'h2)
    note("tick sources");
    wr(8'h60, 8'h40, r);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h60, d, r);
    `CHECK(d, 32'h10)
    rd(8'h64, d, r);
    `CHECK(d, 32'h0)
    rd(8'h68, d, r);
    `CHECK(d, 32'h0)
    @(negedge aclk);
    `CHECK(irq, 1'b0)
    note("reset in mid-run");
    end_of_test();
  end
endmodule : tb
